// ---- dv/bicrp_master.sv ----
// Purpose: Behavioural bus master that issues single reads into the read path.
// Assumes: Each call to read starts just after a rising clock edge.
// Notes:   Released address lines show the inverse of the last address.
`timescale 1ns/100ps
`default_nettype none

module bicrp_master (
    input  wire logic        sys_clk,
    input  wire logic        s_axi_csr_arready,
    input  wire logic [31:0] s_axi_csr_rdata,
    input  wire logic [1:0]  s_axi_csr_rresp,
    input  wire logic        s_axi_csr_rvalid,
    output logic [5:0]       s_axi_csr_araddr,
    output logic [2:0]       s_axi_csr_arprot,
    output logic             s_axi_csr_arvalid,
    output logic             s_axi_csr_rready
);
    initial begin
        s_axi_csr_araddr  = 6'h3F;
        s_axi_csr_arprot  = 3'h0;
        s_axi_csr_arvalid = 1'b0;
        s_axi_csr_rready  = 1'b0;
    end

    // --------------------------------------------------------------------
    // Read transfer
    // --------------------------------------------------------------------
    // The data ready is held back for lag cycles so the slave must stand its answer.
    task automatic read(input logic [5:0] addr, input logic [2:0] prot, input int lag,
                        output logic [31:0] data, output logic [1:0] resp);
        int n;
        data = 'x;
        resp = 'x;
        n    = 0;
        s_axi_csr_araddr  = addr;
        s_axi_csr_arprot  = prot;
        s_axi_csr_arvalid = 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (s_axi_csr_arready !== 1'b1 && n < 20);
        #1;
        s_axi_csr_arvalid = 1'b0;
        s_axi_csr_araddr  = ~addr;
        s_axi_csr_arprot  = ~prot;
        repeat (lag) @(posedge sys_clk);
        if (lag > 0) #1;
        s_axi_csr_rready = 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (s_axi_csr_rvalid !== 1'b1 && n < 20);
        if (s_axi_csr_rvalid === 1'b1) begin
            data = s_axi_csr_rdata;
            resp = s_axi_csr_rresp;
        end
        #1;
        s_axi_csr_rready = 1'b0;
    endtask : read
endmodule : bicrp_master

`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the board information read path.
// Assumes: i_dut at its default parameters; i_dut_off with all four feature switches off.
// Notes:   Reads go through the master model; alarms are driven here.
`timescale 1ns/100ps
`default_nettype none
`include "bicrp_cfg.svh"

module tb_top;
    logic        sys_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic [5:0]  araddr;
    logic [2:0]  arprot;
    logic        arvalid, arready, rvalid, rready, irq;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [2:0]  alm     = 3'h0;
    int          failures  = 0;
    int          cmp_count = 0;
    logic [5:0]  ofs [9];
    logic [31:0] exd [9];
    logic [31:0] d;
    logic [1:0]  r;
    logic [1:0]  er;
    logic [31:0] lnk     = 32'hDEAD_BEEF;
    logic [31:0] rdata_off;
    logic [1:0]  rresp_off;

    always #25 sys_clk = ~sys_clk;

    bicrp_top i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_csr_araddr(araddr),
        .s_axi_csr_arprot(arprot), .s_axi_csr_arvalid(arvalid), .s_axi_csr_arready(arready),
        .s_axi_csr_rdata(rdata), .s_axi_csr_rresp(rresp), .s_axi_csr_rvalid(rvalid),
        .s_axi_csr_rready(rready), .irq(irq), .rev(8'hA5), .rev_date(24'h080915),
        .size(12'h3C1), .fpio(4'h9), .link_status_info(lnk),
        .over_temperature_alarm(alm[0]), .core_supply_alarm(alm[1]), .aux_supply_alarm(alm[2]));

    // A second core with every optional status word absent listens to the same bus.
    bicrp_top #(.HAS_REV_INFO(1'b0), .HAS_SIZE(1'b0), .HAS_FPIO(1'b0), .HAS_LINK_STAT(1'b0)) i_dut_off (
        .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_csr_araddr(araddr), .s_axi_csr_arprot(arprot),
        .s_axi_csr_arvalid(arvalid), .s_axi_csr_arready(), .s_axi_csr_rdata(rdata_off),
        .s_axi_csr_rresp(rresp_off), .s_axi_csr_rvalid(), .s_axi_csr_rready(rready), .irq(),
        .rev(8'hA5), .rev_date(24'h080915), .size(12'h3C1), .fpio(4'h9), .link_status_info(lnk),
        .over_temperature_alarm(alm[0]), .core_supply_alarm(alm[1]), .aux_supply_alarm(alm[2]));

    bicrp_master i_mst (.sys_clk(sys_clk), .s_axi_csr_arready(arready), .s_axi_csr_rdata(rdata),
        .s_axi_csr_rresp(rresp), .s_axi_csr_rvalid(rvalid), .s_axi_csr_araddr(araddr),
        .s_axi_csr_arprot(arprot), .s_axi_csr_arvalid(arvalid), .s_axi_csr_rready(rready));

    // --------------------------------------------------------------------
    // Comparison and verdict
    // --------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // --------------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------------
    initial begin
        ofs = '{`BICRP_OFS_REV, `BICRP_OFS_DATE, `BICRP_OFS_SIZE, `BICRP_OFS_FPIO,
                `BICRP_OFS_LINK, `BICRP_OFS_ALARM, 6'h18, 6'h3C, 6'h02};
        exd = '{32'h0000_00A5, 32'h0008_0915, 32'h0000_03C1, 32'h0000_0009,
                32'hDEAD_BEEF, 32'h0000_0000, 32'h0, 32'h0, 32'h0};
        repeat (20) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        check({31'h0, arready}, 32'h1);
        check({31'h0, rvalid}, 32'h0);
        check({31'h0, irq}, 32'h0);
        // Every register, with the protection bits and the ready stall varied per read.
        for (int i = 0; i < 9; i++) begin
            er = (i < 6) ? `BICRP_RESP_OKAY : `BICRP_RESP_DECERR;
            i_mst.read(ofs[i], i[2:0], i % 4, d, r);
            check(d, exd[i]);
            check({30'h0, r}, {30'h0, er});
            check(rdata_off, (i < 5) ? 32'h0 : exd[i]);
            check({30'h0, rresp_off}, {30'h0, er});
        end
        // A new link status word must show at the next read, not a stale copy.
        lnk = 32'h0123_4567;
        i_mst.read(`BICRP_OFS_LINK, 3'h5, 2, d, r);
        check(d, 32'h0123_4567);
        check(rdata_off, 32'h0);
        for (int k = 0; k < 3; k++) begin
            alm[k] = 1'b1;
            @(posedge sys_clk);
            #1;
            check({31'h0, irq}, 32'h1);
            @(posedge sys_clk);
            #1;
            check({31'h0, irq}, 32'h0);
            i_mst.read(`BICRP_OFS_ALARM, 3'h7, 1, d, r);
            check(d, (32'h1 << k) | (32'h100 << k));
            i_mst.read(`BICRP_OFS_ALARM, 3'h0, 0, d, r);
            check(d, 32'h1 << k);
            alm[k] = 1'b0;
            @(posedge sys_clk);
            #1;
        end
        // A mid-run reset with an alarm pending must clear the sticky state.
        alm[0] = 1'b1;
        @(posedge sys_clk);
        #1;
        rst_b = 1'b0;
        alm[0] = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        check({31'h0, irq}, 32'h0);
        i_mst.read(`BICRP_OFS_ALARM, 3'h0, 0, d, r);
        check(d, 32'h0);
        close_out();
    end

    // The tests need under a hundred cycles; this limit leaves wide margin.
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        close_out();
    end
endmodule : tb_top

`default_nettype wire

// ---- hdl/bicrp_alarm_cell.sv ----
// Purpose: One monitor alarm: registered level, rising-edge pulse, sticky flag.
// Assumes: Alarm input is synchronous to sys_clk.
// Notes:   A rising edge in the clear cycle keeps the sticky flag set.
`timescale 1ns/100ps
`default_nettype none

module bicrp_alarm_cell (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic alarm_in,
    input  wire logic clr,
    output logic      live,
    output logic      rise,
    output logic      sticky
);

    logic lvl_r;
    logic lvl_nxt;
    logic sticky_r;
    logic sticky_nxt;

    always_comb begin
        lvl_nxt    = alarm_in;
        rise       = alarm_in & ~lvl_r;
        sticky_nxt = sticky_r;
        if (clr) begin
            sticky_nxt = 1'b0;
        end
        // Setting after clearing lets a fresh edge survive a clearing read.
        if (rise) begin
            sticky_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            lvl_r    <= 1'b0;
            sticky_r <= 1'b0;
        end else begin
            lvl_r    <= lvl_nxt;
            sticky_r <= sticky_nxt;
        end
    end

    assign live   = lvl_r;
    assign sticky = sticky_r;

endmodule : bicrp_alarm_cell

`default_nettype wire

// ---- hdl/bicrp_cfg.svh ----
// Purpose: Constants for the board information read path: offsets, fields, codes.
// Assumes: Byte addresses on a 6-bit read address, one aligned 32-bit word per register.
// Notes:   Included by bare name; definitions only.
`ifndef BICRP_CFG_SVH
`define BICRP_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define BICRP_OFS_REV       6'h00
`define BICRP_OFS_DATE      6'h04
`define BICRP_OFS_SIZE      6'h08
`define BICRP_OFS_FPIO      6'h0C
`define BICRP_OFS_LINK      6'h10
`define BICRP_OFS_ALARM     6'h14

// ----------------------------------------------------------------------------
// Alarm register fields
// ----------------------------------------------------------------------------
`define BICRP_ALM_NUM       3
`define BICRP_ALM_LIVE_LSB  0
`define BICRP_ALM_STK_LSB   8

// ----------------------------------------------------------------------------
// Read response codes
// ----------------------------------------------------------------------------
`define BICRP_RESP_OKAY     2'h0
`define BICRP_RESP_EXOKAY   2'h1
`define BICRP_RESP_SLVERR   2'h2
`define BICRP_RESP_DECERR   2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BICRP_RST_WORD      32'h0000_0000
`define BICRP_RST_RESP      2'h0

`endif

// ---- hdl/bicrp_pkg.sv ----
// Purpose: Types shared by the board information read path.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds the read channel state type only.
`default_nettype none

package bicrp_pkg;

    // ------------------------------------------------------------------------
    // Read channel states
    // ------------------------------------------------------------------------
    typedef enum logic {
        BICRP_IDLE,
        BICRP_RESP
    } bicrp_state_type;

endpackage : bicrp_pkg

`default_nettype wire

// ---- hdl/bicrp_top.sv ----
// Purpose: Read channel of the board information register core with alarm interrupt.
// Assumes: One clock, synchronous active-low reset, master keeps its side of the handshake.
// Notes:   Status words for absent features read as zero with a normal response.
`timescale 1ns/100ps
`default_nettype none
`include "bicrp_cfg.svh"

module bicrp_top #(
    parameter bit HAS_REV_INFO  = 1'b1,
    parameter bit HAS_SIZE      = 1'b1,
    parameter bit HAS_FPIO      = 1'b1,
    parameter bit HAS_LINK_STAT = 1'b1
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [5:0]  s_axi_csr_araddr,
    input  wire logic [2:0]  s_axi_csr_arprot,
    input  wire logic        s_axi_csr_arvalid,
    output logic             s_axi_csr_arready,
    output logic [31:0]      s_axi_csr_rdata,
    output logic [1:0]       s_axi_csr_rresp,
    output logic             s_axi_csr_rvalid,
    input  wire logic        s_axi_csr_rready,
    output logic             irq,
    input  wire logic [7:0]  rev,
    input  wire logic [23:0] rev_date,
    input  wire logic [11:0] size,
    input  wire logic [3:0]  fpio,
    input  wire logic [31:0] link_status_info,
    input  wire logic        over_temperature_alarm,
    input  wire logic        core_supply_alarm,
    input  wire logic        aux_supply_alarm
);
    import bicrp_pkg::*;

    // ------------------------------------------------------------------------
    // Alarm capture
    // ------------------------------------------------------------------------
    logic [`BICRP_ALM_NUM-1:0] alm_in;
    logic [`BICRP_ALM_NUM-1:0] alm_live;
    logic [`BICRP_ALM_NUM-1:0] alm_rise;
    logic [`BICRP_ALM_NUM-1:0] alm_sticky;
    logic                      alm_clr;
    logic                      irq_r;
    logic                      irq_nxt;

    // Bit order in the alarm word: over-temperature, core supply, auxiliary supply.
    assign alm_in = {aux_supply_alarm, core_supply_alarm, over_temperature_alarm};

    for (genvar i = 0; i < `BICRP_ALM_NUM; i++) begin : g_alarm
        bicrp_alarm_cell u_cell (
            .sys_clk  (sys_clk),
            .rst_b    (rst_b),
            .alarm_in (alm_in[i]),
            .clr      (alm_clr),
            .live     (alm_live[i]),
            .rise     (alm_rise[i]),
            .sticky   (alm_sticky[i])
        );
    end

    // The interrupt pulses for one cycle after each cycle in which any alarm rises, so a stuck alarm
    // cannot hold the line and a level-sensitive receiver would miss repeats.
    always_comb begin
        irq_nxt = |alm_rise;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign irq = irq_r;

    // ------------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------------
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;
    logic        ar_hs;

    assign ar_hs   = s_axi_csr_arvalid & s_axi_csr_arready;
    assign alm_clr = ar_hs & (s_axi_csr_araddr == `BICRP_OFS_ALARM);

    // Protection bits never enter the decode.
    always_comb begin
        rd_word = `BICRP_RST_WORD;
        rd_resp = `BICRP_RESP_OKAY;
        unique case (s_axi_csr_araddr)
            `BICRP_OFS_REV: begin
                if (HAS_REV_INFO) begin
                    rd_word[7:0] = rev;
                end
            end
            `BICRP_OFS_DATE: begin
                if (HAS_REV_INFO) begin
                    rd_word[23:0] = rev_date;
                end
            end
            `BICRP_OFS_SIZE: begin
                if (HAS_SIZE) begin
                    rd_word[11:0] = size;
                end
            end
            `BICRP_OFS_FPIO: begin
                if (HAS_FPIO) begin
                    rd_word[3:0] = fpio;
                end
            end
            `BICRP_OFS_LINK: begin
                if (HAS_LINK_STAT) begin
                    rd_word = link_status_info;
                end
            end
            `BICRP_OFS_ALARM: begin
                rd_word[`BICRP_ALM_LIVE_LSB +: `BICRP_ALM_NUM] = alm_live;
                rd_word[`BICRP_ALM_STK_LSB +: `BICRP_ALM_NUM]  = alm_sticky;
            end
            default: begin
                rd_resp = `BICRP_RESP_DECERR;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    bicrp_state_type st_r;
    bicrp_state_type st_nxt;
    logic            arready_r;
    logic            arready_nxt;
    logic            rvalid_r;
    logic            rvalid_nxt;
    logic [31:0]     rdata_r;
    logic [31:0]     rdata_nxt;
    logic [1:0]      rresp_r;
    logic [1:0]      rresp_nxt;

    always_comb begin
        st_nxt      = st_r;
        arready_nxt = arready_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        unique case (st_r)
            BICRP_IDLE: begin
                if (ar_hs) begin
                    rdata_nxt   = rd_word;
                    rresp_nxt   = rd_resp;
                    rvalid_nxt  = 1'b1;
                    arready_nxt = 1'b0;
                    st_nxt      = BICRP_RESP;
                end
            end
            BICRP_RESP: begin
                // Data and response stay put until the master takes them.
                if (s_axi_csr_rready) begin
                    rvalid_nxt  = 1'b0;
                    arready_nxt = 1'b1;
                    st_nxt      = BICRP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r      <= BICRP_IDLE;
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= `BICRP_RST_WORD;
            rresp_r   <= `BICRP_RST_RESP;
        end else begin
            st_r      <= st_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    assign s_axi_csr_arready = arready_r;
    assign s_axi_csr_rvalid  = rvalid_r;
    assign s_axi_csr_rdata   = rdata_r;
    assign s_axi_csr_rresp   = rresp_r;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_ar_capture_resp: assert property (ar_hs |=> s_axi_csr_rvalid && !s_axi_csr_arready)
        else $error("Accepted read did not produce a response next cycle.");
    a_rvalid_hold: assert property (s_axi_csr_rvalid && !s_axi_csr_rready |=>
            s_axi_csr_rvalid && $stable(s_axi_csr_rdata) && $stable(s_axi_csr_rresp))
        else $error("Read data or response changed before the master took it.");
    a_resp_no_excl: assert property (s_axi_csr_rvalid |-> s_axi_csr_rresp != `BICRP_RESP_EXOKAY)
        else $error("Exclusive success returned on a read.");
    a_decode_error: assert property (ar_hs && s_axi_csr_araddr > `BICRP_OFS_ALARM |=>
            s_axi_csr_rresp == `BICRP_RESP_DECERR)
        else $error("Unmapped read did not return a decode error.");
    a_rev_word: assert property (HAS_REV_INFO && ar_hs && s_axi_csr_araddr == `BICRP_OFS_REV |=>
            s_axi_csr_rdata == {24'h0, $past(rev)} && s_axi_csr_rresp == `BICRP_RESP_OKAY)
        else $error("Revision word wrong.");
    a_date_word: assert property (HAS_REV_INFO && ar_hs && s_axi_csr_araddr == `BICRP_OFS_DATE |=>
            s_axi_csr_rdata == {8'h0, $past(rev_date)})
        else $error("Revision date word wrong.");
    a_size_word: assert property (HAS_SIZE && ar_hs && s_axi_csr_araddr == `BICRP_OFS_SIZE |=>
            s_axi_csr_rdata == {20'h0, $past(size)})
        else $error("Size word wrong.");
    a_fpio_word: assert property (HAS_FPIO && ar_hs && s_axi_csr_araddr == `BICRP_OFS_FPIO |=>
            s_axi_csr_rdata == {28'h0, $past(fpio)})
        else $error("Front-panel identifier word wrong.");
    a_link_word: assert property (HAS_LINK_STAT && ar_hs && s_axi_csr_araddr == `BICRP_OFS_LINK |=>
            s_axi_csr_rdata == $past(link_status_info))
        else $error("Link status word wrong.");
    a_temp_alarm_irq: assert property ($rose(over_temperature_alarm) |=> irq)
        else $error("Over-temperature edge raised no interrupt.");
    a_core_alarm_irq: assert property ($rose(core_supply_alarm) |=> irq)
        else $error("Core supply edge raised no interrupt.");
    a_aux_alarm_irq: assert property ($rose(aux_supply_alarm) |=> irq)
        else $error("Auxiliary supply edge raised no interrupt.");
    a_irq_cause: assert property (irq |-> $past(|(alm_in & ~alm_live)))
        else $error("Interrupt pulsed with no alarm edge.");
    a_reset_init: assert property (disable iff (1'b0) !rst_b |=>
            s_axi_csr_arready && !s_axi_csr_rvalid && !irq)
        else $error("Reset did not return the core to its initial state.");

endmodule : bicrp_top

`default_nettype wire
